// ==== rtl/usc_consts.svh ====
// Offsets, bit positions and reset values
`ifndef USC_CONSTS_SVH
`define USC_CONSTS_SVH

// ********************************************************
// Register byte offsets
// ********************************************************
`define USC_OFS_CTRL      8'h00
`define USC_OFS_RTO       8'h14
`define USC_OFS_REQ       8'h18
`define USC_OFS_STAT      8'h1C
`define USC_OFS_CLR       8'h20
`define USC_OFS_RXD       8'h24
`define USC_OFS_TXD       8'h28

// ********************************************************
// Control register fields
// ********************************************************
`define USC_CTRL_RX_ON    0
`define USC_CTRL_RTO_ON   1
`define USC_CTRL_FLOW_ON  2
`define USC_CTRL_OVR_OFF  3
`define USC_CTRL_ONE_SMP  4
`define USC_CTRL_PAR_ON   5
`define USC_CTRL_PAR_ODD  6
`define USC_CTRL_WORD9    7
`define USC_CTRL_W        8
`define USC_CTRL_RESET    8'h00

// ********************************************************
// Request register fields
// ********************************************************
`define USC_REQ_RX_FLUSH  3
`define USC_REQ_TX_FLUSH  4

// ********************************************************
// Status flag positions
// ********************************************************
`define USC_ST_PE         0
`define USC_ST_FE         1
`define USC_ST_NOISE      2
`define USC_ST_ORE        3
`define USC_ST_IDLE       4
`define USC_ST_RX_FULL_FLAG       5
`define USC_ST_TC         6
`define USC_ST_TXE        7
`define USC_ST_LBD        8
`define USC_ST_FLOW_INPUT_CHANGE_FLAG      9
`define USC_ST_CTS        10
`define USC_ST_RTO        11
`define USC_ST_EB         12
`define USC_ST_CM         17
`define USC_ST_TX_DONE_GUARD_FLAG      25

// ********************************************************
// Flag-clear positions
// ********************************************************
`define USC_CL_PE         0
`define USC_CL_FE         1
`define USC_CL_NOISE      2
`define USC_CL_ORE        3
`define USC_CL_IDLE       4
`define USC_CL_TC         6
`define USC_CL_TX_DONE_GUARD_FLAG      7
`define USC_CL_LBD        8
`define USC_CL_CTS        9
`define USC_CL_RTO        11
`define USC_CL_EB         12
`define USC_CL_CM         17

// ********************************************************
// Reset values and widths
// ********************************************************
`define USC_TXE_RESET     1'b1
`define USC_TC_RESET      1'b1
`define USC_WORD_W        9
`define USC_RTO_MAX_W     24

`endif

// ==== rtl/usc_pkg.sv ====
// Types shared by the register block
package usc_pkg;

  typedef logic [8:0] usc_word_t;

  typedef enum logic [1:0] {
    USC_BUS_IDLE = 2'b01,
    USC_BUS_ACK  = 2'b10
  } usc_bus_state_t;

endpackage

// ==== rtl/usc_rx_timeout.sv ====
// Receive timeout counter counting bit periods of line silence
`timescale 1ns/1ps
`include "usc_consts.svh"

module usc_rx_timeout #(
  parameter int RTO_W = 24
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Control
  input  wire logic             enable_i,
  input  wire logic             bit_tick_i,
  input  wire logic             line_activity_i,
  input  wire logic [RTO_W-1:0] timeout_value_i,
  // Event
  output logic                  expired_o
);

  logic [RTO_W-1:0] count_reg;
  logic             armed_reg;
  logic             expired_reg;

  generate
    if (RTO_W < 1 || RTO_W > `USC_RTO_MAX_W) begin : g_bad_width
      $error("usc_rx_timeout: RTO_W out of range");
    end
  endgenerate

  // Disable acts at once; no flag can come from a stale count
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !enable_i) begin // RULE2
      count_reg   <= '0;
      armed_reg   <= 1'b1;
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= 1'b0;
      if (line_activity_i) begin
        count_reg <= '0;
        armed_reg <= 1'b1;
      end else if (armed_reg) begin
        // Compare with >= so a value lowered below the count fires too
        if (count_reg >= timeout_value_i) begin // RULE1
          expired_reg <= 1'b1;
          armed_reg   <= 1'b0;
        end else if (bit_tick_i) begin // RULE19
          count_reg <= RTO_W'(count_reg + 1'b1);
        end
      end
    end
  end

  assign expired_o = expired_reg;

endmodule

// ==== rtl/usc_regs.sv ====
// Status, flag-clear and data registers with a Wishbone slave
// How it works
// RULE1 - Enabled timeout elapsing without line activity sets timeout flag.
// RULE2 - Receiver off disables the timeout counter immediately.
// RULE3 - Flow status bit reads the inverse of the flow input pin.
// RULE4 - Flow input enabled: any pin level change sets change flag.
// RULE5 - Detected line break sets line-break flag; clear bit removes it.
// RULE6 - Transmit empty sets when data moves on, clears on write; flush sets it.
// RULE7 - Frame done with transmit empty sets complete; clear bit or data write clears.
// RULE8 - Received word sets receive-full; data read or receive flush clears it.
// RULE9 - Idle sets on detection; after clearing, needs a start bit first.
// RULE10 - New word while full or DMA pending sets overrun; clear bit removes.
// RULE11 - Overrun-detect-off suppresses overrun and holds its flag at zero.
// RULE12 - Noise sets noise flag unless single-sample mode is selected.
// RULE13 - Desync, excess noise or break character sets framing error flag.
// RULE14 - Failed parity check sets parity error flag; clear bit removes.
// RULE15 - Clear bits remove char match, block end and guard-done flags.
// RULE16 - Receive data holds nine bits; parity bit returns in top used bit.
// RULE17 - Transmit data takes nine bits; parity replaces top used bit.
// RULE18 - Reduced instances hold timeout, break, idle, match, block, guard flags at reset.
// RULE19 - Timeout value counts in bit periods of the receive line.
// RULE20 - Zero clear bits change nothing; flag-clear register reads zero.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
`include "usc_consts.svh"

module usc_regs
  import usc_pkg::*;
#(
  parameter int ADR_W        = 8,
  parameter int RTO_W        = 24,
  parameter bit FULL_FEATURE = 1'b1
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             rst_n_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Receive core events
  input  wire logic             rx_word_valid_i,
  input  wire usc_pkg::usc_word_t rx_word_i,
  input  wire logic             rx_noise_i,
  input  wire logic             rx_frame_err_i,
  input  wire logic             rx_break_char_i,
  input  wire logic             rx_parity_err_i,
  input  wire logic             rx_line_break_i,
  input  wire logic             rx_idle_i,
  input  wire logic             rx_start_i,
  input  wire logic             rx_bit_tick_i,
  input  wire logic             rx_activity_i,
  input  wire logic             rx_dma_pending_i,
  input  wire logic             char_match_i,
  input  wire logic             block_end_i,
  input  wire logic             tx_guard_done_i,
  // Transmit core handshake
  input  wire logic             tx_load_ack_i,
  input  wire logic             tx_frame_done_i,
  output usc_pkg::usc_word_t    tx_word_o,
  output logic                  tx_pending_o,
  // Flow control pin
  input  wire logic             cts_i,
  // Configuration to the serial core
  output logic                  cfg_rx_on_o,
  output logic                  cfg_single_sample_o,
  output logic                  cfg_parity_on_o,
  output logic                  cfg_parity_odd_o,
  output logic                  cfg_word9_o
);

  import usc_pkg::*;

  // ********************************************************
  // Elaboration checks
  // ********************************************************
  generate
    if (ADR_W < 6) begin : g_bad_adr
      $error("usc_regs: ADR_W too small for the map");
    end
    if (RTO_W < 1 || RTO_W > `USC_RTO_MAX_W) begin : g_bad_rto
      $error("usc_regs: RTO_W out of range");
    end
  endgenerate

  // ********************************************************
  // Functions
  // ********************************************************
  function automatic logic [31:0] usc_lane_mask(input logic [3:0] sel);
    usc_lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic usc_hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    usc_hit = ({adr[ADR_W-1:2], 2'b00} == ADR_W'(ofs));
  endfunction

  // Parity covers only the data bits below the top used bit
  function automatic usc_word_t usc_tx_frame(input usc_word_t data, input logic par_on,
                                             input logic par_odd, input logic word9);
    usc_word_t frame;
    frame = word9 ? data : {1'b0, data[7:0]};
    if (par_on) begin
      if (word9) begin
        frame[8] = (^data[7:0]) ^ par_odd;
      end else begin
        frame[7] = (^data[6:0]) ^ par_odd;
      end
    end
    usc_tx_frame = frame;
  endfunction

  // ********************************************************
  // Wishbone slave
  // ********************************************************
  usc_bus_state_t   bus_state_reg;
  logic             ack_reg;
  logic [31:0]      rd_data_reg;
  logic [31:0]      rd_data;
  logic [31:0]      wmask;
  logic [31:0]      wdata;
  logic             access;
  logic             wr;
  logic             rd;

  assign access = wb_cyc_i && wb_stb_i && (bus_state_reg == USC_BUS_IDLE);
  assign wr     = access && wb_we_i;
  assign rd     = access && !wb_we_i;
  assign wmask  = usc_lane_mask(wb_sel_i);
  assign wdata  = wb_dat_i & wmask;

  // Ack one cycle after the request is taken, then a forced gap
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bus_state_reg <= USC_BUS_IDLE;
      ack_reg       <= 1'b0;
    end else begin
      case (bus_state_reg)
        USC_BUS_IDLE: begin
          if (access) begin
            bus_state_reg <= USC_BUS_ACK;
            ack_reg       <= 1'b1;
          end
        end
        USC_BUS_ACK: begin
          bus_state_reg <= USC_BUS_IDLE;
          ack_reg       <= 1'b0;
        end
        default: begin
          bus_state_reg <= USC_BUS_IDLE;
          ack_reg       <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Control and timeout value registers
  // ********************************************************
  logic [`USC_CTRL_W-1:0] ctrl_reg;
  logic [RTO_W-1:0]       rto_value_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= `USC_CTRL_RESET;
    end else if (wr && usc_hit(wb_adr_i, `USC_OFS_CTRL)) begin
      ctrl_reg <= (ctrl_reg & ~wmask[`USC_CTRL_W-1:0]) | wdata[`USC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !FULL_FEATURE) begin // RULE18
      rto_value_reg <= '0;
    end else if (wr && usc_hit(wb_adr_i, `USC_OFS_RTO)) begin
      rto_value_reg <= (rto_value_reg & ~wmask[RTO_W-1:0]) | wdata[RTO_W-1:0];
    end
  end

  logic rx_on;
  logic ovr_off;
  logic par_on;
  logic word9;
  assign rx_on   = ctrl_reg[`USC_CTRL_RX_ON];
  assign ovr_off = ctrl_reg[`USC_CTRL_OVR_OFF];
  assign par_on  = ctrl_reg[`USC_CTRL_PAR_ON];
  assign word9   = ctrl_reg[`USC_CTRL_WORD9];

  // ********************************************************
  // Clear and request strobes
  // ********************************************************
  logic [31:0] clr;
  logic        tx_flush;
  logic        rx_flush;
  logic        txd_wr;
  logic        rxd_rd;

  // Only ones clear; zeros and masked lanes leave flags alone
  assign clr      = (wr && usc_hit(wb_adr_i, `USC_OFS_CLR)) ? wdata : 32'h0; // RULE20
  assign tx_flush = wr && usc_hit(wb_adr_i, `USC_OFS_REQ) && wdata[`USC_REQ_TX_FLUSH];
  assign rx_flush = wr && usc_hit(wb_adr_i, `USC_OFS_REQ) && wdata[`USC_REQ_RX_FLUSH];
  assign txd_wr   = wr && usc_hit(wb_adr_i, `USC_OFS_TXD) && (wb_sel_i[1:0] != 2'h0);
  assign rxd_rd   = rd && usc_hit(wb_adr_i, `USC_OFS_RXD);

  // ********************************************************
  // Receive timeout
  // ********************************************************
  logic rto_expired;

  usc_rx_timeout #(
    .RTO_W (RTO_W)
  ) u_rx_timeout (
    .clock_i         (clock_i),
    .rst_n_i         (rst_n_i),
    .enable_i        (rx_on && ctrl_reg[`USC_CTRL_RTO_ON] && FULL_FEATURE), // RULE2
    .bit_tick_i      (rx_bit_tick_i), // RULE19
    .line_activity_i (rx_activity_i),
    .timeout_value_i (rto_value_reg),
    .expired_o       (rto_expired)
  );

  // ********************************************************
  // Receive data and flags
  // ********************************************************
  usc_word_t rx_data_reg;
  logic      rx_full_flag_reg;
  logic      ore_reg;
  logic      noise_reg;
  logic      fe_reg;
  logic      pe_reg;
  logic      idle_reg;
  logic      idle_armed_reg;
  logic      lbd_reg;
  logic      rto_reg;
  logic      ovr_event;

  assign ovr_event = rx_word_valid_i && (rx_full_flag_reg || rx_dma_pending_i) && !ovr_off; // RULE10 RULE11

  // Overrun keeps unread data; detection off overwrites
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || rx_flush) begin
      rx_data_reg <= '0;
    end else if (rx_word_valid_i && (!rx_full_flag_reg || ovr_off)) begin
      rx_data_reg <= word9 ? rx_word_i : {1'b0, rx_word_i[7:0]}; // RULE16
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rx_full_flag_reg <= 1'b0;
    end else begin
      rx_full_flag_reg <= rx_word_valid_i || (rx_full_flag_reg && !rxd_rd && !rx_flush); // RULE8
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || ovr_off) begin // RULE11
      ore_reg <= 1'b0;
    end else begin
      ore_reg <= ovr_event || (ore_reg && !clr[`USC_CL_ORE]); // RULE10
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      noise_reg <= 1'b0;
      fe_reg    <= 1'b0;
      pe_reg    <= 1'b0;
    end else begin
      noise_reg <= (rx_noise_i && !ctrl_reg[`USC_CTRL_ONE_SMP]) || (noise_reg && !clr[`USC_CL_NOISE]); // RULE12
      fe_reg    <= rx_frame_err_i || rx_break_char_i || (fe_reg && !clr[`USC_CL_FE]); // RULE13
      pe_reg    <= rx_parity_err_i || (pe_reg && !clr[`USC_CL_PE]); // RULE14
    end
  end

  // Re-arms only on a start bit: one flag per idle period
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !FULL_FEATURE) begin // RULE18
      idle_reg       <= 1'b0;
      idle_armed_reg <= 1'b1;
    end else begin
      idle_reg <= (rx_idle_i && idle_armed_reg) || (idle_reg && !clr[`USC_CL_IDLE]); // RULE9
      if (rx_start_i) begin
        idle_armed_reg <= 1'b1;
      end else if (clr[`USC_CL_IDLE] || (rx_idle_i && idle_armed_reg)) begin
        idle_armed_reg <= 1'b0; // RULE9
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !FULL_FEATURE) begin // RULE18
      lbd_reg <= 1'b0;
      rto_reg <= 1'b0;
    end else begin
      lbd_reg <= rx_line_break_i || (lbd_reg && !clr[`USC_CL_LBD]); // RULE5
      rto_reg <= rto_expired || (rto_reg && !clr[`USC_CL_RTO]); // RULE1
    end
  end

  // ********************************************************
  // Match, block end and guard flags
  // ********************************************************
  logic cm_reg;
  logic eb_reg;
  logic tx_done_guard_flag_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !FULL_FEATURE) begin // RULE18
      cm_reg    <= 1'b0;
      eb_reg    <= 1'b0;
      tx_done_guard_flag_reg <= 1'b0;
    end else begin
      cm_reg    <= char_match_i || (cm_reg && !clr[`USC_CL_CM]); // RULE15
      eb_reg    <= block_end_i || (eb_reg && !clr[`USC_CL_EB]); // RULE15
      tx_done_guard_flag_reg <= tx_guard_done_i || (tx_done_guard_flag_reg && !clr[`USC_CL_TX_DONE_GUARD_FLAG] && !txd_wr); // RULE15
    end
  end

  // ********************************************************
  // Flow control input
  // ********************************************************
  logic cts_level_reg;
  logic flow_input_change_flag_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cts_level_reg <= 1'b1;
      flow_input_change_flag_reg     <= 1'b0;
    end else begin
      cts_level_reg <= cts_i;
      flow_input_change_flag_reg     <= (ctrl_reg[`USC_CTRL_FLOW_ON] && (cts_i != cts_level_reg)) // RULE4
                       || (flow_input_change_flag_reg && !clr[`USC_CL_CTS]);
    end
  end

  // ********************************************************
  // Transmit data and flags
  // ********************************************************
  usc_word_t tx_data_reg;
  usc_word_t tx_word_reg;
  logic      txe_reg;
  logic      pend_reg;
  logic      tc_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_data_reg <= '0;
    end else if (txd_wr) begin
      tx_data_reg <= (tx_data_reg & ~wmask[8:0]) | wdata[8:0];
    end
  end

  // Set wins over a write in the same cycle
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      txe_reg  <= `USC_TXE_RESET;
      pend_reg <= !`USC_TXE_RESET;
      tc_reg   <= `USC_TC_RESET;
    end else begin
      txe_reg  <= tx_load_ack_i || tx_flush || (txe_reg && !txd_wr); // RULE6
      pend_reg <= !(tx_load_ack_i || tx_flush || (txe_reg && !txd_wr)); // RULE6
      tc_reg  <= (tx_frame_done_i && txe_reg) || (tc_reg && !clr[`USC_CL_TC] && !txd_wr); // RULE7
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tx_word_reg <= '0;
    end else begin
      tx_word_reg <= usc_tx_frame(tx_data_reg, par_on, ctrl_reg[`USC_CTRL_PAR_ODD], word9); // RULE17
    end
  end

  // ********************************************************
  // Read data
  // ********************************************************
  logic [31:0] status;

  always_comb begin
    status                = 32'h0;
    status[`USC_ST_PE]    = pe_reg;
    status[`USC_ST_FE]    = fe_reg;
    status[`USC_ST_NOISE] = noise_reg;
    status[`USC_ST_ORE]   = ore_reg;
    status[`USC_ST_IDLE]  = idle_reg;
    status[`USC_ST_RX_FULL_FLAG]  = rx_full_flag_reg;
    status[`USC_ST_TC]    = tc_reg;
    status[`USC_ST_TXE]   = txe_reg;
    status[`USC_ST_LBD]   = lbd_reg;
    status[`USC_ST_FLOW_INPUT_CHANGE_FLAG] = flow_input_change_flag_reg;
    status[`USC_ST_CTS]   = !cts_level_reg; // RULE3
    status[`USC_ST_RTO]   = rto_reg;
    status[`USC_ST_EB]    = eb_reg;
    status[`USC_ST_CM]    = cm_reg;
    status[`USC_ST_TX_DONE_GUARD_FLAG] = tx_done_guard_flag_reg;
  end

  // Write-only and unmapped words read as zero
  always_comb begin
    rd_data = 32'h0;
    if (usc_hit(wb_adr_i, `USC_OFS_CTRL)) begin
      rd_data = {{(32-`USC_CTRL_W){1'b0}}, ctrl_reg};
    end else if (usc_hit(wb_adr_i, `USC_OFS_RTO)) begin
      rd_data = 32'(rto_value_reg);
    end else if (usc_hit(wb_adr_i, `USC_OFS_STAT)) begin
      rd_data = status;
    end else if (usc_hit(wb_adr_i, `USC_OFS_RXD)) begin
      rd_data = {23'h0, rx_data_reg}; // RULE16
    end else if (usc_hit(wb_adr_i, `USC_OFS_TXD)) begin
      rd_data = {23'h0, tx_data_reg};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= 32'h0;
    end else if (rd) begin
      rd_data_reg <= rd_data; // RULE20
    end
  end

  // ********************************************************
  // Configuration outputs
  // ********************************************************
  logic [4:0] cfg_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cfg_reg <= 5'h00;
    end else begin
      cfg_reg <= {word9, ctrl_reg[`USC_CTRL_PAR_ODD], par_on, ctrl_reg[`USC_CTRL_ONE_SMP], rx_on};
    end
  end

  assign wb_ack_o            = ack_reg;
  assign wb_dat_o            = rd_data_reg;
  assign tx_word_o           = tx_word_reg;
  assign tx_pending_o        = pend_reg;
  assign cfg_rx_on_o         = cfg_reg[0];
  assign cfg_single_sample_o = cfg_reg[1];
  assign cfg_parity_on_o     = cfg_reg[2];
  assign cfg_parity_odd_o    = cfg_reg[3];
  assign cfg_word9_o         = cfg_reg[4];

endmodule

// ==== test/usc_regs_assertions.sv ====
// Port-level checks of the register block
`timescale 1ns/1ps
module usc_regs_assertions (
  // Clock and reset
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  // Bus
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Core side
  input wire logic              cts_i,
  input wire logic              tx_load_ack_i,
  input wire usc_pkg::usc_word_t tx_word_o,
  input wire logic              tx_pending_o,
  input wire logic              cfg_parity_on_o,
  input wire logic              cfg_parity_odd_o,
  input wire logic              cfg_word9_o
);
  // ****************
  // Checks
  // ****************
  logic       tk;
  logic       rdk;
  logic [2:0] cf;
  // Slave ignores the strobe in its ack cycle
  assign tk  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rdk = wb_ack_o && !wb_we_i;
  assign cf  = {cfg_parity_on_o, cfg_parity_odd_o, cfg_word9_o};
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_follows_req: assert property (tk |=> wb_ack_o)
    else $error("no ack");
  a_txd_fills: assert property (
    tk && wb_we_i && wb_adr_i == 8'h28 && wb_sel_i[0] && !tx_load_ack_i |-> ##[1:2] tx_pending_o)
    else $error("write left empty");
  a_load_empties: assert property (
    tx_load_ack_i && !(tk && wb_we_i && wb_adr_i == 8'h28) |-> ##[1:2] !tx_pending_o)
    else $error("load kept pending");
  a_flush_empties: assert property (
    tk && wb_we_i && wb_adr_i == 8'h18 && wb_sel_i[0] && wb_dat_i[4] |-> ##[1:2] !tx_pending_o)
    else $error("flush kept pending");
  // Settle guard: word may lag the configuration by a cycle
  a_tx_parity: assert property (
    cf[2] && cf[0] && cf == $past(cf) && cf == $past(cf, 2)
    |-> tx_word_o[8] == (^tx_word_o[7:0] ^ cfg_parity_odd_o))
    else $error("bad tx parity");
  a_cts_inverse: assert property (
    rdk && wb_adr_i == 8'h1C && cts_i == $past(cts_i, 2) && cts_i == $past(cts_i, 3)
    |-> wb_dat_o[10] == !cts_i)
    else $error("cts bit wrong");
  a_clear_reads_zero: assert property (rdk && wb_adr_i == 8'h20 |-> wb_dat_o == 32'h0)
    else $error("clear reg nonzero");
  a_rxd_nine_bits: assert property (rdk && wb_adr_i == 8'h24 |-> wb_dat_o[31:9] == 23'h0)
    else $error("rx data too wide");
endmodule

// ==== test/usc_far_end.sv ====
// Far-side model: receive/transmit core events and the flow pin
`timescale 1ns/1ps
module usc_far_end (
  // Clock
  input  wire logic        clock_i,
  // Requests from the bench
  input  wire logic [15:0] req_i,
  input  wire logic [8:0]  word_i,
  input  wire logic        cts_i,
  // Toward the block
  output logic      [15:0] ev_o = 16'h0,
  output logic      [8:0]  word_o = 9'h0,
  output logic             cts_o = 1'b1
);
  always_ff @(posedge clock_i) begin
    ev_o   <= req_i;
    // Churns off strobe to expose stale use
    word_o <= req_i[0] ? word_i : ~word_o;
    cts_o  <= cts_i;
  end
endmodule

// ==== test/usc_regs_tb.sv ====
// Self-checking bench of the register block
`timescale 1ns/1ps
module usc_regs_tb;
  import usc_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_n_i, req, we, cts_l, cts, pend, ack;
  logic [7:0]  adr;
  logic [31:0] dat, q, rd;
  logic [15:0] ev, p;
  usc_word_t   wd, word, txw;
  logic [4:0]  cfg;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          ei[9] = '{1, 2, 3, 4, 5, 6, 11, 12, 13};
  int          sb[9] = '{2, 1, 1, 0, 8, 4, 17, 12, 25};
  int          cb[9] = '{2, 1, 1, 0, 8, 4, 17, 12, 7};
  always #20 clock_i = ~clock_i;
  usc_far_end u_far (.clock_i(clock_i), .req_i(ev), .word_i(wd), .cts_i(cts_l), .ev_o(p), .word_o(word),
    .cts_o(cts));
  usc_regs DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .rx_word_valid_i(p[0]), .rx_word_i(word), .rx_noise_i(p[1]), .rx_frame_err_i(p[2]),
    .rx_break_char_i(p[3]), .rx_parity_err_i(p[4]), .rx_line_break_i(p[5]), .rx_idle_i(p[6]),
    .rx_start_i(p[7]), .rx_bit_tick_i(p[8]), .rx_activity_i(p[9]), .rx_dma_pending_i(p[10]),
    .char_match_i(p[11]), .block_end_i(p[12]), .tx_guard_done_i(p[13]), .tx_load_ack_i(p[14]),
    .tx_frame_done_i(p[15]), .tx_word_o(txw), .tx_pending_o(pend), .cts_i(cts), .cfg_rx_on_o(cfg[0]),
    .cfg_single_sample_o(cfg[1]), .cfg_parity_on_o(cfg[2]), .cfg_parity_odd_o(cfg[3]), .cfg_word9_o(cfg[4]));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock_i);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rd;
    req <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pulse(input logic [15:0] m);
    @(posedge clock_i);
    ev <= m;
    @(posedge clock_i);
    ev <= 16'h0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic pin(input logic v);
    @(posedge clock_i);
    cts_l <= v;
    repeat (4) @(posedge clock_i);
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    rst_n_i = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    dat = 32'h0;
    ev = 16'h0;
    wd = 9'h1A5;
    cts_l = 1'b1;
    repeat (16) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rc(8'h1C, 32'hC0);
    rc(8'h20, 32'h0);
    $display("reset test done");
    pulse(16'h0001);
    rc(8'h1C, 32'hE0);
    pulse(16'h0001);
    rc(8'h1C, 32'hE8);
    rc(8'h24, 32'h0A5);
    rc(8'h1C, 32'hC8);
    wr(8'h20, 32'h8);
    pulse(16'h0401);
    rc(8'h1C, 32'hE8);
    wr(8'h20, 32'h8);
    wr(8'h18, 32'h8);
    rc(8'h1C, 32'hC0);
    wr(8'h00, 32'h18);
    pulse(16'h0001);
    pulse(16'h0003);
    rc(8'h1C, 32'hE0);
    rc(8'h24, 32'h0A5);
    wr(8'h00, 32'h0);
    $display("receive test done");
    for (int i = 0; i < 9; i++) begin
      pulse(16'h0080);
      pulse(16'h1 << ei[i]);
      wr(8'h20, ~(32'h1 << cb[i]) & ~32'h40);
      rc(8'h1C, 32'hC0 | (32'h1 << sb[i]));
      wr(8'h20, 32'h1 << cb[i]);
      rc(8'h1C, 32'hC0);
    end
    pulse(16'h0040);
    wr(8'h20, 32'h10);
    pulse(16'h0040);
    rc(8'h1C, 32'hC0);
    $display("flag test done");
    wr(8'h00, 32'h4);
    pin(1'b0);
    rc(8'h1C, 32'h6C0);
    wr(8'h20, 32'h200);
    rc(8'h1C, 32'h4C0);
    pin(1'b1);
    rc(8'h1C, 32'h2C0);
    wr(8'h20, 32'h200);
    wr(8'h00, 32'h0);
    pin(1'b0);
    rc(8'h1C, 32'h4C0);
    pin(1'b1);
    $display("flow test done");
    wr(8'h00, 32'hA0);
    wr(8'h28, 32'h1FF);
    rc(8'h1C, 32'h0);
    chk({23'h0, txw}, 32'h0FF);
    pulse(16'h4000);
    rc(8'h1C, 32'h80);
    pulse(16'h8000);
    rc(8'h1C, 32'hC0);
    wr(8'h00, 32'hE0);
    wr(8'h28, 32'h003);
    rc(8'h28, 32'h003);
    chk({23'h0, txw}, 32'h103);
    chk({cfg, pend}, 32'h39);
    wr(8'h18, 32'h10);
    rc(8'h1C, 32'h80);
    pulse(16'h8000);
    wr(8'h20, 32'h40);
    rc(8'h1C, 32'h80);
    $display("transmit test done");
    wr(8'h14, 32'h3);
    wr(8'h00, 32'h3);
    pulse(16'h0200);
    repeat (2) pulse(16'h0100);
    rc(8'h1C, 32'h80);
    pulse(16'h0100);
    rc(8'h1C, 32'h880);
    wr(8'h20, 32'h800);
    rc(8'h1C, 32'h80);
    wr(8'h00, 32'h2);
    pulse(16'h0200);
    repeat (5) pulse(16'h0100);
    rc(8'h1C, 32'h80);
    $display("timeout test done");
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    stop_test();
  end
endmodule
bind usc_regs usc_regs_assertions u_chk (.*);
